// [verilog/tmcp_timer.v]
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "tmcp_consts.vh"

module tmcp_timer (
	input wire clk,
	input wire rst,
	input wire [7:0] addr,
	input wire [31:0] wdata,
	input wire wr_en,
	input wire rd_en,
	output reg [31:0] rdata,
	input wire snapshot_input,
	output reg [2:0] match_output_pins,
	output reg irq
);

	// Register state.
	reg [4:0] flags_q;
	reg [4:0] flags_d;
	reg [1:0] run_q;
	reg [1:0] run_d;
	reg [31:0] count_q;
	reg [31:0] count_d;
	reg [31:0] divlim_q;
	reg [31:0] divcnt_q;
	reg [31:0] divcnt_d;
	reg [11:0] mact_q;
	reg [31:0] cmp_q [0:3];
	reg [2:0] snapctl_q;
	reg [31:0] snap_q;
	reg [31:0] snap_d;
	reg [11:0] pinctl_q;
	reg [11:0] pinctl_d;
	reg [3:0] srcctl_q;
	reg [3:0] pulse_q;
	reg [31:0] rdata_d;

	// Input synchroniser and edge history.
	reg sin_m_q;
	reg sin_s_q;
	reg sin_h_q;

	// Decoded events.
	reg rise;
	reg fall;
	reg adv;
	reg tick;
	reg snap_ev;
	integer i;

	// Per-channel results from the four compare units.
	wire [3:0] hit;
	wire [3:0] wrap_req;
	wire [3:0] halt_req;
	wire [3:0] flag_set;
	wire [3:0] pin_nx;
	wire wrap = |wrap_req;
	wire halt = |halt_req;

	wire wr_flags = wr_en && addr == `TMCP_OFS_FLAGS;
	wire wr_run = wr_en && addr == `TMCP_OFS_RUN;
	wire wr_count = wr_en && addr == `TMCP_OFS_COUNT;
	wire wr_divcnt = wr_en && addr == `TMCP_OFS_DIVCNT;
	wire wr_pinctl = wr_en && addr == `TMCP_OFS_PINCTL;
	wire wr_divlim = wr_en && addr == `TMCP_OFS_DIVLIM;
	wire wr_mact = wr_en && addr == `TMCP_OFS_MACT;
	wire wr_cmp0 = wr_en && addr == `TMCP_OFS_CMP0;
	wire wr_cmp1 = wr_en && addr == `TMCP_OFS_CMP1;
	wire wr_cmp2 = wr_en && addr == `TMCP_OFS_CMP2;
	wire wr_cmp3 = wr_en && addr == `TMCP_OFS_CMP3;
	wire wr_snapctl = wr_en && addr == `TMCP_OFS_SNAPCTL;
	wire wr_srcctl = wr_en && addr == `TMCP_OFS_SRCCTL;
	wire wr_pulse = wr_en && addr == `TMCP_OFS_PULSE;

	// Software value of the pin states, before any match acts on them.
	wire [3:0] pin_wr = wr_pinctl ? wdata[3:0] : pinctl_q[3:0];

	// Two flops bring the pin into the clock domain; a third keeps history.
	always @(posedge clk) begin
		if (rst) begin
			sin_m_q <= 1'b0;
			sin_s_q <= 1'b0;
			sin_h_q <= 1'b0;
		end else begin
			sin_m_q <= snapshot_input;
			sin_s_q <= sin_m_q;
			sin_h_q <= sin_s_q;
		end
	end

	// Counting, match and snapshot logic.
	always @* begin
		rise = sin_s_q && !sin_h_q;
		fall = !sin_s_q && sin_h_q;
		// Source select: prescaled clock or edges of the snapshot input.
		case (srcctl_q[1:0])
			`TMCP_SRC_TIMER: adv = 1'b1;
			`TMCP_SRC_RISE: adv = rise;
			`TMCP_SRC_FALL: adv = fall;
			`TMCP_SRC_BOTH: adv = rise || fall;
			default: adv = 1'b0;
		endcase
		adv = adv && run_q[`TMCP_RUN_EN] && !run_q[`TMCP_RUN_CLR];
		tick = adv && divcnt_q == divlim_q;
	end

	// All four compare channels act, whether or not a pin exists.
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_chan
			tmcp_match_chan u_chan (
				.tick(tick),
				.wrap(wrap),
				.count(count_q),
				.cmp(cmp_q[g]),
				.mact(mact_q[3*g +: 3]),
				.act(pinctl_q[`TMCP_PIN_CTL_LSB+2*g +: 2]),
				.pulse(pulse_q[g]),
				.pin_q(pinctl_q[g]),
				.pin_wr(pin_wr[g]),
				.hit(hit[g]),
				.wrap_req(wrap_req[g]),
				.halt_req(halt_req[g]),
				.flag_set(flag_set[g]),
				.pin_d(pin_nx[g])
			);
		end
	endgenerate

	// Main counter: clear bit, then software, then counting.
	always @* begin
		count_d = count_q;
		if (run_q[`TMCP_RUN_CLR]) begin
			count_d = 32'h00000000;
		end else if (wr_count) begin
			count_d = wdata;
		end else if (tick) begin
			if (wrap) begin
				count_d = 32'h00000000;
			end else if (!halt) begin
				count_d = count_q + 32'h00000001;
			end
		end
	end

	// Divider count wraps at the limit.
	always @* begin
		divcnt_d = divcnt_q;
		if (run_q[`TMCP_RUN_CLR]) begin
			divcnt_d = 32'h00000000;
		end else if (wr_divcnt) begin
			divcnt_d = wdata;
		end else if (tick) begin
			divcnt_d = 32'h00000000;
		end else if (adv) begin
			divcnt_d = divcnt_q + 32'h00000001;
		end
	end

	// A stop match clears the enable bit over any write.
	always @* begin
		run_d = wr_run ? wdata[1:0] : run_q;
		if (halt) begin
			run_d[`TMCP_RUN_EN] = 1'b0;
		end
	end

	// Snapshot on the chosen input edges.
	always @* begin
		snap_ev = (rise && snapctl_q[`TMCP_SNAP_RISE]) ||
			(fall && snapctl_q[`TMCP_SNAP_FALL]);
		snap_d = snap_ev ? count_q : snap_q;
	end

	// Flags: write one clears, a new event in the same cycle wins.
	always @* begin
		flags_d = flags_q;
		if (wr_flags) begin
			flags_d = flags_q & ~wdata[4:0];
		end
		flags_d[3:0] = flags_d[3:0] | flag_set;
		if (snap_ev && snapctl_q[`TMCP_SNAP_IRQ]) begin
			flags_d[`TMCP_FLAG_SNAP] = 1'b1;
		end
	end

	// Match pin states; hardware actions override a software write.
	always @* begin
		pinctl_d = {(wr_pinctl ? wdata[11:4] : pinctl_q[11:4]), pin_nx};
	end

	// Read mux; reserved bits and unmapped offsets read zero.
	always @* begin
		rdata_d = 32'h00000000;
		if (rd_en) begin
			case (addr)
				`TMCP_OFS_FLAGS: rdata_d = {27'h0, flags_q};
				`TMCP_OFS_RUN: rdata_d = {30'h0, run_q};
				`TMCP_OFS_COUNT: rdata_d = count_q;
				`TMCP_OFS_DIVLIM: rdata_d = divlim_q;
				`TMCP_OFS_DIVCNT: rdata_d = divcnt_q;
				`TMCP_OFS_MACT: rdata_d = {20'h0, mact_q};
				`TMCP_OFS_CMP0: rdata_d = cmp_q[0];
				`TMCP_OFS_CMP1: rdata_d = cmp_q[1];
				`TMCP_OFS_CMP2: rdata_d = cmp_q[2];
				`TMCP_OFS_CMP3: rdata_d = cmp_q[3];
				`TMCP_OFS_SNAPCTL: rdata_d = {29'h0, snapctl_q};
				`TMCP_OFS_SNAPVAL: rdata_d = snap_q;
				`TMCP_OFS_PINCTL: rdata_d = {20'h0, pinctl_q};
				`TMCP_OFS_SRCCTL: rdata_d = {28'h0, srcctl_q};
				`TMCP_OFS_PULSE: rdata_d = {28'h0, pulse_q};
				default: rdata_d = 32'h00000000;
			endcase
		end
	end

	// Main and divider counts with the run control bits.
	always @(posedge clk) begin
		if (rst) begin
			run_q <= 2'h0;
			count_q <= `TMCP_RST_VAL;
			divcnt_q <= `TMCP_RST_VAL;
		end else begin
			run_q <= run_d;
			count_q <= count_d;
			divcnt_q <= divcnt_d;
		end
	end

	// Divider limit, changed by software only.
	always @(posedge clk) begin
		if (rst) begin
			divlim_q <= `TMCP_RST_VAL;
		end else if (wr_divlim) begin
			divlim_q <= wdata;
		end
	end

	// Match actions and the four compare values.
	always @(posedge clk) begin
		if (rst) begin
			mact_q <= 12'h000;
			for (i = 0; i < 4; i = i + 1) begin
				cmp_q[i] <= `TMCP_RST_VAL;
			end
		end else begin
			if (wr_mact) begin
				mact_q <= wdata[11:0];
			end
			if (wr_cmp0) begin
				cmp_q[0] <= wdata;
			end
			if (wr_cmp1) begin
				cmp_q[1] <= wdata;
			end
			if (wr_cmp2) begin
				cmp_q[2] <= wdata;
			end
			if (wr_cmp3) begin
				cmp_q[3] <= wdata;
			end
		end
	end

	// Snapshot control and the captured value; the value is read-only.
	always @(posedge clk) begin
		if (rst) begin
			snapctl_q <= 3'h0;
			snap_q <= `TMCP_RST_VAL;
		end else begin
			if (wr_snapctl) begin
				snapctl_q <= wdata[2:0];
			end
			snap_q <= snap_d;
		end
	end

	// Count source and pulse mode selects.
	always @(posedge clk) begin
		if (rst) begin
			srcctl_q <= 4'h0;
			pulse_q <= 4'h0;
		end else begin
			if (wr_srcctl) begin
				srcctl_q <= wdata[3:0];
			end
			if (wr_pulse) begin
				pulse_q <= wdata[3:0];
			end
		end
	end

	// Event flags, and the request that is high while any flag is set.
	always @(posedge clk) begin
		if (rst) begin
			flags_q <= 5'h00;
			irq <= 1'b0;
		end else begin
			flags_q <= flags_d;
			irq <= |flags_d;
		end
	end

	// Pin states and the pins themselves load on the same edge.
	always @(posedge clk) begin
		if (rst) begin
			pinctl_q <= 12'h000;
			match_output_pins <= 3'h0;
		end else begin
			pinctl_q <= pinctl_d;
			match_output_pins <= pinctl_d[2:0];
		end
	end

	// Read data stands only in the cycle after the strobe.
	always @(posedge clk) begin
		if (rst) begin
			rdata <= `TMCP_RST_VAL;
		end else begin
			rdata <= rdata_d;
		end
	end

endmodule

// One compare channel: match detection, its actions and its pin state.
module tmcp_match_chan (
	input wire tick,
	input wire wrap,
	input wire [31:0] count,
	input wire [31:0] cmp,
	input wire [2:0] mact,
	input wire [1:0] act,
	input wire pulse,
	input wire pin_q,
	input wire pin_wr,
	output reg hit,
	output reg wrap_req,
	output reg halt_req,
	output reg flag_set,
	output reg pin_d
);

	// A match counts only on a divider tick, against the old count.
	always @* begin
		hit = tick && count == cmp;
		flag_set = hit && mact[0];
		wrap_req = hit && mact[1];
		halt_req = hit && mact[2];
		pin_d = pin_wr;
		if (pulse) begin
			// PWM: high at match, low at period restart unless compare is zero.
			if (hit) begin
				pin_d = 1'b1;
			end else if (wrap) begin
				pin_d = cmp == 32'h00000000;
			end
		end else if (hit) begin
			case (act)
				`TMCP_PIN_LOW: pin_d = 1'b0;
				`TMCP_PIN_HIGH: pin_d = 1'b1;
				`TMCP_PIN_TOGGLE: pin_d = !pin_q;
				default: pin_d = pin_wr;
			endcase
		end
	end

endmodule

// [verilog/tmcp_consts.vh]
`ifndef TMCP_CONSTS_VH
`define TMCP_CONSTS_VH

// Register byte offsets.
`define TMCP_OFS_FLAGS 8'h00
`define TMCP_OFS_RUN 8'h04
`define TMCP_OFS_COUNT 8'h08
`define TMCP_OFS_DIVLIM 8'h0C
`define TMCP_OFS_DIVCNT 8'h10
`define TMCP_OFS_MACT 8'h14
`define TMCP_OFS_CMP0 8'h18
`define TMCP_OFS_CMP1 8'h1C
`define TMCP_OFS_CMP2 8'h20
`define TMCP_OFS_CMP3 8'h24
`define TMCP_OFS_SNAPCTL 8'h28
`define TMCP_OFS_SNAPVAL 8'h2C
`define TMCP_OFS_PINCTL 8'h3C
`define TMCP_OFS_SRCCTL 8'h70
`define TMCP_OFS_PULSE 8'h74

// Reset value of every implemented bit.
`define TMCP_RST_VAL 32'h00000000

// Run control fields.
`define TMCP_RUN_EN 0
`define TMCP_RUN_CLR 1

// Event flag layout: four match flags, then the snapshot flag.
`define TMCP_FLAG_SNAP 4

// Snapshot control fields.
`define TMCP_SNAP_RISE 0
`define TMCP_SNAP_FALL 1
`define TMCP_SNAP_IRQ 2

// Count source modes in bits 1:0.
`define TMCP_SRC_TIMER 2'h0
`define TMCP_SRC_RISE 2'h1
`define TMCP_SRC_FALL 2'h2
`define TMCP_SRC_BOTH 2'h3

// Match pin actions, two bits per channel starting at bit 4.
`define TMCP_PIN_CTL_LSB 4
`define TMCP_PIN_NONE 2'h0
`define TMCP_PIN_LOW 2'h1
`define TMCP_PIN_HIGH 2'h2
`define TMCP_PIN_TOGGLE 2'h3

`endif

// [dv/tmcp_timer_sva.sv]
`timescale 1ns/1ps
module tmcp_timer_sva (
	input wire clk,
	input wire rst,
	input wire [7:0] addr,
	input wire [31:0] wdata,
	input wire wr_en,
	input wire rd_en,
	input wire [31:0] rdata,
	input wire snapshot_input,
	input wire [2:0] match_output_pins,
	input wire irq
);
	// One clock domain, so clock and reset are given once.
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_rdata_idle_zero: assert property (!rd_en |=> rdata == 32'h0)
		else $error("read data not idle");
	a_reset_outputs_zero: assert property ($past(rst) |-> !irq && match_output_pins == 3'h0)
		else $error("outputs not cleared by reset");
	a_unmapped_reads_zero: assert property (rd_en && addr == 8'h40 |=> rdata == 32'h0)
		else $error("unmapped read not zero");
	a_flags_five_bits: assert property (rd_en && addr == 8'h00 |=> rdata[31:5] == 27'h0)
		else $error("flags beyond bit four");
	a_run_two_bits: assert property (rd_en && addr == 8'h04 |=> rdata[31:2] == 30'h0)
		else $error("run control beyond bit one");
	a_limit_readback: assert property (wr_en && addr == 8'h0C ##1 rd_en && addr == 8'h0C
		|=> rdata == $past(wdata, 2)) else $error("divider limit lost");
	a_source_readback: assert property (wr_en && addr == 8'h70 ##1 rd_en && addr == 8'h70
		|=> rdata == ($past(wdata, 2) & 32'hF)) else $error("source control lost");
	a_pulse_readback: assert property (wr_en && addr == 8'h74 ##1 rd_en && addr == 8'h74
		|=> rdata == ($past(wdata, 2) & 32'hF)) else $error("pulse select lost");
	c_irq_raised: cover property ($rose(irq));
	c_pins_driven: cover property (match_output_pins == 3'h5);
	c_snap_read: cover property (rd_en && addr == 8'h2C);
endmodule
bind tmcp_timer tmcp_timer_sva u_sva (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
	.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .snapshot_input(snapshot_input),
	.match_output_pins(match_output_pins), .irq(irq));

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
	logic clk, rst, wr_en, rd_en, snapshot_input, irq;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [2:0] match_output_pins;
	int n_errors, checks_done, highs;
	logic [7:0] ofs [16] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
		8'h20, 8'h24, 8'h28, 8'h2C, 8'h3C, 8'h70, 8'h74, 8'h40};
	tmcp_timer uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .snapshot_input(snapshot_input),
		.match_output_pins(match_output_pins), .irq(irq));
	// Clock of 10 ns period.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 chk(rdata, e);
	endtask
	// Write followed at once by a read of the same place.
	task wrrd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		wr(a, d);
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task give_verdict;
		if (n_errors == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Cuts a hung run short.
	initial begin
		#100000;
		n_errors++;
		give_verdict;
	end
	// Main sequence; the pulse test measures pin high time over two periods.
	initial begin
		rst = 1'b1;
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		snapshot_input = 1'b0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		foreach (ofs[i]) rd(ofs[i], 32'h0);
		wrrd(8'h0C, 32'h2, 32'h2);
		wr(8'h04, 32'h1);
		repeat (9) @(posedge clk);
		wr(8'h04, 32'h0);
		rd(8'h08, 32'h3);
		rd(8'h10, 32'h2);
		repeat (5) @(posedge clk);
		rd(8'h08, 32'h3);
		wr(8'h08, 32'h12345678);
		rd(8'h08, 32'h12345678);
		wr(8'h04, 32'h2);
		rd(8'h08, 32'h0);
		wrrd(8'h0C, 32'h0, 32'h0);
		wr(8'h1C, 32'h5);
		wr(8'h14, 32'h18);
		wr(8'h04, 32'h1);
		repeat (9) @(posedge clk);
		wr(8'h04, 32'h0);
		rd(8'h08, 32'h5);
		rd(8'h00, 32'h2);
		chk(irq, 1);
		wr(8'h00, 32'h0);
		rd(8'h00, 32'h2);
		wr(8'h00, 32'h2);
		rd(8'h00, 32'h0);
		chk(irq, 0);
		wr(8'h08, 32'h0);
		wr(8'h18, 32'h1);
		wr(8'h20, 32'h3);
		wr(8'h24, 32'h4);
		wr(8'h1C, 32'h2);
		wr(8'h3C, 32'h362);
		wr(8'h14, 32'hA00);
		wr(8'h04, 32'h1);
		repeat (20) @(posedge clk);
		rd(8'h08, 32'h4);
		rd(8'h04, 32'h0);
		rd(8'h00, 32'h8);
		rd(8'h3C, 32'h365);
		chk(match_output_pins, 3'h5);
		wr(8'h08, 32'h100);
		wr(8'h28, 32'h5);
		snapshot_input <= 1'b1;
		repeat (6) @(posedge clk);
		rd(8'h2C, 32'h100);
		rd(8'h00, 32'h18);
		wr(8'h2C, 32'h55);
		rd(8'h2C, 32'h100);
		wr(8'h28, 32'h2);
		wr(8'h08, 32'h200);
		snapshot_input <= 1'b0;
		repeat (6) @(posedge clk);
		rd(8'h2C, 32'h200);
		wr(8'h28, 32'h0);
		wr(8'h08, 32'h0);
		wrrd(8'h70, 32'h1, 32'h1);
		wr(8'h04, 32'h1);
		repeat (3) begin
			repeat (4) @(posedge clk);
			snapshot_input <= 1'b1;
			repeat (4) @(posedge clk);
			snapshot_input <= 1'b0;
		end
		repeat (4) @(posedge clk);
		rd(8'h08, 32'h3);
		wr(8'h24, 32'h10);
		wr(8'h70, 32'h3);
		snapshot_input <= 1'b1;
		repeat (6) @(posedge clk);
		snapshot_input <= 1'b0;
		repeat (6) @(posedge clk);
		rd(8'h08, 32'h5);
		wr(8'h70, 32'h2);
		snapshot_input <= 1'b1;
		repeat (6) @(posedge clk);
		snapshot_input <= 1'b0;
		repeat (6) @(posedge clk);
		rd(8'h08, 32'h6);
		wr(8'h24, 32'h4);
		wr(8'h04, 32'h0);
		wrrd(8'h70, 32'h0, 32'h0);
		wr(8'h08, 32'h0);
		wr(8'h18, 32'h2);
		wr(8'h14, 32'h400);
		wr(8'h3C, 32'h0);
		wrrd(8'h74, 32'h1, 32'h1);
		wr(8'h04, 32'h1);
		repeat (12) @(posedge clk);
		highs = 0;
		repeat (10) begin
			@(posedge clk);
			#1 highs += match_output_pins[0];
		end
		chk(highs, 4);
		give_verdict;
	end
endmodule
